// ===== memory_map_pkg.sv
package memory_map_pkg;

  // i/o port offsets
  localparam logic [15:0] map_pointer_port = 16'h0011;
  localparam logic [15:0] map_entry_port = 16'h0012;
  localparam logic [15:0] planar_control_port = 16'h006b;

  // planar control layout
  localparam int remap_bit = 0;
  localparam int parity_bit = 7;
  localparam int first_block_bit = 1;
  localparam int block_disable_count = 6;
  localparam logic [7:0] planar_reset = 8'h00;
  localparam logic [3:0] first_disable_block = 4'h4;

  // map entry layout
  localparam int map_entries = 36;
  localparam int entry_width = 10;
  localparam int entry_valid_bit = 7;
  localparam logic [9:0] entry_reset = 10'h000;
  localparam logic [5:0] pointer_reset = 6'h00;

  // pages of 16k, blocks of 64k
  localparam logic [5:0] low_window_first = 6'h10;
  localparam logic [5:0] low_window_last = 6'h27;
  localparam logic [5:0] high_window_first = 6'h30;
  localparam logic [5:0] high_window_last = 6'h3b;
  localparam logic [5:0] high_window_base = 6'h18;
  localparam logic [3:0] low_bank_blocks = 4'h2;
  localparam logic [3:0] system_blocks = 4'ha;
  localparam logic [3:0] remapped_blocks = 4'h8;
  localparam logic [3:0] remap_offset = 4'h8;
  localparam int static_selects = 10;
  localparam logic [3:0] no_bank = 4'hf;

  // memory access timing at the rated 150 ns part
  localparam int access_time_ns = 150;
  localparam int clock_period_ns = 25;
  localparam int access_cycles = (access_time_ns + clock_period_ns - 1) / clock_period_ns;

  typedef struct packed {
    logic low_row_n;
    logic high_row_n;
    logic [9:0] chip_selects_n;
    logic read_n;
    logic write_hi_n;
    logic write_lo_n;
    logic [3:0] bank_lines;
    logic [3:0] expanded_rows_n;
    logic [9:0] mem_addr;
  } mem_ctrl_type;

endpackage : memory_map_pkg

// ===== system_and_expanded_memory_map.sv
// How it works
// R01 - strap high dynamic controls, low static selects
// R02 - ten static selects per 64k, plus strobes
// R03 - row strobe 0 low 128k, 1 next 512k
// R04 - four bank lines, all ones when idle
// R05 - bit0 clear: normal two bank decode
// R06 - bit0 set: remap second bank over low
// R07 - bits 1..6 disable 64k blocks 40000 up
// R08 - planar control cleared on reset
// R09 - expanded hit blocks system strobes and selects
// R10 - refresh asserts both rows, none when static
// R11 - parity error steers bit 7 by bank
// R12 - writing one clears bit 7
// R13 - map holds 36 ten-bit entries
// R14 - 64 pages, only two windows mappable
// R15 - page count follows density strap or static
// R16 - 2m or 8m expanded dynamic memory
// R17 - cpu a19..a14 index the current map
// R18 - pointer port selects entry for data port
// R19 - data port word layout, upper bits zero
// R20 - ten multiplexed lines, tenth idle for 256k
// R21 - zero wait states at 150 ns parts
// R22 - enabled entries map, others fall through
// R23 - indices above 35 ignored, read zero
`timescale 1ns/1ps
module system_and_expanded_memory_map (
  input wire logic clock,
  input wire logic rst,
  input wire logic memory_type_strap,
  input wire logic chip_density_strap,
  input wire logic [15:0] io_addr,
  input wire logic io_write,
  input wire logic io_read,
  input wire logic [15:0] io_wdata,
  output logic [15:0] io_rdata,
  output logic io_rdata_valid,
  input wire logic mem_cycle,
  input wire logic mem_read,
  input wire logic mem_write,
  input wire logic [19:0] mem_addr,
  input wire logic byte_high_n,
  input wire logic column_phase,
  input wire logic refresh_indicator_n,
  input wire logic parity_error,
  output logic low_bank_row_strobe_n,
  output logic high_bank_row_strobe_n,
  output logic [9:0] static_chip_selects_n,
  output logic static_read_strobe_n,
  output logic static_write_strobe_hi_n,
  output logic static_write_strobe_lo_n,
  output logic [3:0] expanded_bank_lines,
  output logic [3:0] expanded_row_strobes_n,
  output logic [9:0] multiplexed_mem_addr,
  output logic [8:0] expanded_page,
  output logic expanded_memory_hit,
  output logic [3:0] wait_states
);

  localparam int map_entries_local = memory_map_pkg::map_entries;

  logic [9:0] current_map [map_entries_local];
  logic [9:0] next_current_map [map_entries_local];
  logic [5:0] current_map_pointer;
  logic [5:0] next_current_map_pointer;
  logic [7:0] planar_memory_control;
  logic [7:0] next_planar_memory_control;
  logic [15:0] next_io_rdata;
  logic next_io_rdata_valid;
  memory_map_pkg::mem_ctrl_type ctrl;
  memory_map_pkg::mem_ctrl_type next_ctrl;
  logic [8:0] next_expanded_page;
  logic next_expanded_memory_hit;

  // decode terms
  logic [5:0] page;
  logic [3:0] block;
  logic page_mappable;
  logic [5:0] page_index;
  logic [9:0] entry;
  logic mapped;
  logic remap;
  logic block_disabled;
  logic low_hit;
  logic high_hit;
  logic [3:0] phys_block;
  logic [22:0] phys_addr;
  logic [3:0] bank_select;
  logic refresh;
  logic [8:0] entry_page;

  always_comb begin
    page = mem_addr[19:14];
    block = mem_addr[19:16];
    remap = planar_memory_control[memory_map_pkg::remap_bit];
    refresh = ~refresh_indicator_n;
    // only the two windows have entries
    page_mappable = 1'b0; // R14
    page_index = 6'h00;
    if (page >= memory_map_pkg::low_window_first && page <= memory_map_pkg::low_window_last) begin
      page_mappable = 1'b1; // R14
      page_index = page - memory_map_pkg::low_window_first; // R17
    end else if (page >= memory_map_pkg::high_window_first && page <= memory_map_pkg::high_window_last) begin
      page_mappable = 1'b1; // R14
      page_index = page - memory_map_pkg::high_window_first + memory_map_pkg::high_window_base; // R17
    end
    entry = current_map[page_index]; // R17
    mapped = mem_cycle & page_mappable & entry[memory_map_pkg::entry_valid_bit]; // R22
    entry_page = {entry[9:8], entry[6:0]}; // R19
    if (!memory_type_strap || chip_density_strap) begin
      entry_page[8:7] = 2'b00; // R15
    end
    // per-block disable of the second bank
    block_disabled = 1'b0;
    for (int i = 0; i < memory_map_pkg::block_disable_count; i++) begin
      if (block == memory_map_pkg::first_disable_block + 4'(i) &&
          planar_memory_control[memory_map_pkg::first_block_bit + i]) begin
        block_disabled = 1'b1; // R07
      end
    end
    low_hit = 1'b0;
    high_hit = 1'b0;
    phys_block = block;
    if (mem_cycle && !mapped && !block_disabled) begin // R09
      if (!remap) begin
        low_hit = block < memory_map_pkg::low_bank_blocks; // R05
        high_hit = block >= memory_map_pkg::low_bank_blocks && block < memory_map_pkg::system_blocks; // R05
      end else begin
        high_hit = block < memory_map_pkg::remapped_blocks; // R06
        if (block < memory_map_pkg::low_bank_blocks) begin
          phys_block = block + memory_map_pkg::remap_offset; // R06
        end
      end
    end
    // physical address for the multiplexer
    if (mapped) begin
      phys_addr = {entry_page, mem_addr[13:0]};
    end else begin
      phys_addr = {3'b000, phys_block, mem_addr[15:0]};
    end
    if (chip_density_strap) begin
      bank_select = 4'b0001 << phys_addr[20:19]; // R16
    end else begin
      bank_select = 4'b0001 << phys_addr[22:21]; // R16
    end
  end

  always_comb begin
    next_ctrl.low_row_n = 1'b1;
    next_ctrl.high_row_n = 1'b1;
    next_ctrl.chip_selects_n = '1;
    next_ctrl.read_n = 1'b1;
    next_ctrl.write_hi_n = 1'b1;
    next_ctrl.write_lo_n = 1'b1;
    next_ctrl.bank_lines = memory_map_pkg::no_bank; // R04
    next_ctrl.expanded_rows_n = '1;
    next_ctrl.mem_addr = 10'h000;
    next_expanded_page = 9'h000;
    next_expanded_memory_hit = mapped; // R22
    if (mapped) begin
      next_expanded_page = entry_page; // R17
    end
    if (memory_type_strap) begin // R01
      if (refresh) begin
        next_ctrl.low_row_n = 1'b0; // R10
        next_ctrl.high_row_n = 1'b0; // R10
        next_ctrl.expanded_rows_n = 4'h0; // R10
      end else begin
        next_ctrl.low_row_n = ~low_hit; // R03
        next_ctrl.high_row_n = ~high_hit; // R03
        if (mapped) begin
          next_ctrl.expanded_rows_n = ~bank_select; // R16
        end
      end
      if (chip_density_strap) begin
        next_ctrl.mem_addr = column_phase ? {1'b0, phys_addr[18:10]} : {1'b0, phys_addr[9:1]}; // R20
      end else begin
        next_ctrl.mem_addr = column_phase ? phys_addr[20:11] : phys_addr[10:1]; // R20
      end
    end else begin
      // static mode: no refresh, chip selects per 64k block
      if (!refresh) begin // R10
        for (int i = 0; i < memory_map_pkg::static_selects; i++) begin
          if ((low_hit || high_hit) && phys_block == 4'(i)) begin
            next_ctrl.chip_selects_n[i] = 1'b0; // R02
          end
        end
        if (mapped) begin
          next_ctrl.bank_lines = entry[5:2]; // R04
        end
        if (low_hit || high_hit || mapped) begin
          next_ctrl.read_n = ~mem_read; // R02
          next_ctrl.write_hi_n = ~(mem_write & ~byte_high_n); // R02
          next_ctrl.write_lo_n = ~(mem_write & ~mem_addr[0]); // R02
        end
      end
    end
  end

  // register ports
  logic valid_index;
  always_comb begin
    valid_index = current_map_pointer < 6'(map_entries_local); // R23
    next_current_map = current_map;
    next_current_map_pointer = current_map_pointer;
    next_planar_memory_control = planar_memory_control;
    next_io_rdata = io_rdata;
    next_io_rdata_valid = io_read;
    if (io_write) begin
      if (io_addr == memory_map_pkg::map_pointer_port) begin
        next_current_map_pointer = io_wdata[5:0]; // R18
      end
      if (io_addr == memory_map_pkg::map_entry_port && valid_index) begin
        next_current_map[current_map_pointer] = io_wdata[9:0]; // R19
      end
      if (io_addr == memory_map_pkg::planar_control_port) begin
        next_planar_memory_control[6:0] = io_wdata[6:0];
        if (io_wdata[memory_map_pkg::parity_bit]) begin
          next_planar_memory_control[memory_map_pkg::parity_bit] = 1'b0; // R12
        end
      end
    end
    // a parity event in the same cycle beats the software clear
    if (parity_error && mem_read) begin
      if (low_hit) begin
        next_planar_memory_control[memory_map_pkg::parity_bit] = 1'b1; // R11
      end else if (high_hit) begin
        next_planar_memory_control[memory_map_pkg::parity_bit] = 1'b0; // R11
      end
    end
    if (io_read) begin
      next_io_rdata = 16'h0000;
      if (io_addr == memory_map_pkg::map_pointer_port) begin
        next_io_rdata = {10'h000, current_map_pointer}; // R18
      end else if (io_addr == memory_map_pkg::map_entry_port && valid_index) begin
        next_io_rdata = {6'h00, current_map[current_map_pointer]}; // R19
      end else if (io_addr == memory_map_pkg::planar_control_port) begin
        next_io_rdata = {8'h00, planar_memory_control};
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < map_entries_local; i++) begin
        current_map[i] <= memory_map_pkg::entry_reset; // R13
      end
      current_map_pointer <= memory_map_pkg::pointer_reset;
      planar_memory_control <= memory_map_pkg::planar_reset; // R08
      io_rdata <= 16'h0000;
      io_rdata_valid <= 1'b0;
      ctrl <= '{low_row_n: 1'b1, high_row_n: 1'b1, chip_selects_n: '1, read_n: 1'b1, write_hi_n: 1'b1,
                write_lo_n: 1'b1, bank_lines: memory_map_pkg::no_bank, expanded_rows_n: '1,
                mem_addr: 10'h000};
      expanded_page <= 9'h000;
      expanded_memory_hit <= 1'b0;
    end else begin
      current_map <= next_current_map;
      current_map_pointer <= next_current_map_pointer;
      planar_memory_control <= next_planar_memory_control;
      io_rdata <= next_io_rdata;
      io_rdata_valid <= next_io_rdata_valid;
      ctrl <= next_ctrl;
      expanded_page <= next_expanded_page;
      expanded_memory_hit <= next_expanded_memory_hit;
    end
  end

  assign low_bank_row_strobe_n = ctrl.low_row_n;
  assign high_bank_row_strobe_n = ctrl.high_row_n;
  assign static_chip_selects_n = ctrl.chip_selects_n;
  assign static_read_strobe_n = ctrl.read_n;
  assign static_write_strobe_hi_n = ctrl.write_hi_n;
  assign static_write_strobe_lo_n = ctrl.write_lo_n;
  assign expanded_bank_lines = ctrl.bank_lines;
  assign expanded_row_strobes_n = ctrl.expanded_rows_n;
  assign multiplexed_mem_addr = ctrl.mem_addr;
  // no wait states requested for rated parts
  assign wait_states = (memory_map_pkg::access_cycles <= 6) ? 4'h0 : 4'h1; // R21

endmodule : system_and_expanded_memory_map

// ===== memory_map_checker.sv
`timescale 1ns/1ps
module memory_map_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic memory_type_strap,
  input wire logic io_read,
  input wire logic io_rdata_valid,
  input wire logic mem_cycle,
  input wire logic mem_write,
  input wire logic [19:0] mem_addr,
  input wire logic refresh_indicator_n,
  input wire logic low_bank_row_strobe_n,
  input wire logic high_bank_row_strobe_n,
  input wire logic [9:0] static_chip_selects_n,
  input wire logic static_read_strobe_n,
  input wire logic static_write_strobe_lo_n,
  input wire logic [3:0] expanded_bank_lines,
  input wire logic [8:0] expanded_page,
  input wire logic expanded_memory_hit,
  input wire logic [3:0] wait_states
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  static_rows_a: assert property (!memory_type_strap |=> low_bank_row_strobe_n && high_bank_row_strobe_n)
    else $error("row strobe in static mode");
  refresh_rows_a: assert property (memory_type_strap && !refresh_indicator_n
    |=> !low_bank_row_strobe_n && !high_bank_row_strobe_n)
    else $error("refresh without both row strobes");
  quiet_idle_a: assert property (!mem_cycle && refresh_indicator_n
    |=> &static_chip_selects_n && low_bank_row_strobe_n && high_bank_row_strobe_n && static_read_strobe_n)
    else $error("strobe with no access");
  hit_blocks_a: assert property (expanded_memory_hit
    |-> &static_chip_selects_n && low_bank_row_strobe_n && high_bank_row_strobe_n)
    else $error("system strobe on mapped access");
  idle_bank_a: assert property (!expanded_memory_hit |-> expanded_bank_lines == 4'hf)
    else $error("bank lines not ones");
  page_zero_a: assert property (!expanded_memory_hit |-> expanded_page == 9'h000)
    else $error("page without mapped access");
  one_select_a: assert property ($onehot0(~static_chip_selects_n))
    else $error("several chip selects");
  write_lo_a: assert property (!static_write_strobe_lo_n |-> $past(mem_write && !mem_addr[0]))
    else $error("low write strobe without low write");
  read_answer_a: assert property (io_read |=> io_rdata_valid)
    else $error("read not answered");
  valid_cause_a: assert property (io_rdata_valid |-> $past(io_read))
    else $error("stray read valid");
  zero_wait_a: assert property (wait_states == 4'h0)
    else $error("wait states inserted");
  cover property (memory_type_strap && !refresh_indicator_n);
  cover property (expanded_memory_hit);
  cover property (!static_write_strobe_lo_n);
endmodule : memory_map_checker

bind system_and_expanded_memory_map memory_map_checker chk (.*);

// ===== memory_chips.sv
`timescale 1ns/1ps
module memory_chips (
  input wire logic mem_cycle,
  input wire logic mem_read,
  input wire logic bad,
  output logic parity_error
);
  // a read of a cell holding bad parity flags an error; no address goes with it
  assign parity_error = bad && mem_cycle && mem_read;
endmodule : memory_chips

// ===== system_and_expanded_memory_map_test.sv
`timescale 1ns/1ps
module system_and_expanded_memory_map_test;
  logic clock = 0, rst = 1, strap = 1, io_write = 0, io_read = 0, mem_cycle = 0, mem_read = 0, mem_write = 0;
  logic refresh_n = 1, bad = 0, parity_error, io_rdata_valid, lr, hr, rd_n, wh_n, wl_n, hit;
  logic [15:0] io_addr = 0, io_wdata = 0, io_rdata, m, r;
  logic [19:0] mem_addr = 0;
  logic [9:0] cs, ma;
  logic [3:0] bank, er, ws;
  logic [8:0] pg;
  int n_errors = 0, checks = 0;
  always #12.5 clock = ~clock;
  memory_chips far (.mem_cycle(mem_cycle), .mem_read(mem_read), .bad(bad), .parity_error(parity_error));
  system_and_expanded_memory_map dut (.clock(clock), .rst(rst), .memory_type_strap(strap),
    .chip_density_strap(1'b1), .io_addr(io_addr), .io_write(io_write), .io_read(io_read),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .mem_cycle(mem_cycle),
    .mem_read(mem_read), .mem_write(mem_write), .mem_addr(mem_addr), .byte_high_n(1'b0),
    .column_phase(1'b0), .refresh_indicator_n(refresh_n), .parity_error(parity_error),
    .low_bank_row_strobe_n(lr), .high_bank_row_strobe_n(hr), .static_chip_selects_n(cs),
    .static_read_strobe_n(rd_n), .static_write_strobe_hi_n(wh_n), .static_write_strobe_lo_n(wl_n),
    .expanded_bank_lines(bank), .expanded_row_strobes_n(er), .multiplexed_mem_addr(ma),
    .expanded_page(pg), .expanded_memory_hit(hit), .wait_states(ws));
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic chk_reg(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin n_errors++; $display("mismatch %s expected %h seen %h", n, e, g); end
  endtask : chk_reg
  task automatic chk_mem(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin n_errors++; $display("mismatch %s expected %h seen %h", n, e, g); end
  endtask : chk_mem
  task automatic io(logic [15:0] a, logic [15:0] d, logic wr);
    @(posedge clock);
    io_addr <= a; io_wdata <= d; io_write <= wr; io_read <= !wr;
    @(posedge clock);
    io_write <= 0; io_read <= 0;
    if (!wr) begin @(posedge clock); #1 r = io_rdata; end
  endtask : io
  // one access or refresh cycle, outputs taken the cycle after
  task automatic mem(logic [19:0] a, logic wr, logic rf);
    @(posedge clock);
    mem_addr <= a; mem_cycle <= !rf; mem_read <= !wr && !rf; mem_write <= wr && !rf; refresh_n <= !rf;
    @(posedge clock);
    mem_cycle <= 0; mem_read <= 0; mem_write <= 0; refresh_n <= 1;
    #1 m = {lr, hr, cs, bank};
  endtask : mem
  initial begin #(25 * 5000); n_errors++; conclude(); end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 0;
    io(16'h006b, 0, 0); chk_reg("planar", 16'h0000, r);
    io(16'h0011, 16'h0045, 1); io(16'h0011, 0, 0); chk_reg("pointer", 16'h0005, r);
    io(16'h0012, 16'hffff, 1); io(16'h0012, 0, 0); chk_reg("entry", 16'h03ff, r);
    io(16'h0011, 16'h0024, 1); io(16'h0012, 16'h0083, 1);
    io(16'h0012, 0, 0); chk_reg("entry", 16'h0000, r);
    mem(20'h10000, 0, 0); chk_mem("rows", 16'h7fff, m);
    mem(20'h90000, 0, 0); chk_mem("rows", 16'hbfff, m);
    mem(20'h00000, 0, 1); chk_mem("rows", 16'h3fff, m);
    bad <= 1; mem(20'h10000, 0, 0); bad <= 0;
    io(16'h006b, 0, 0); chk_reg("planar", 16'h0080, r);
    io(16'h006b, 16'h0000, 1); io(16'h006b, 0, 0); chk_reg("planar", 16'h0080, r);
    io(16'h006b, 16'h0080, 1); io(16'h006b, 0, 0); chk_reg("planar", 16'h0000, r);
    bad <= 1; mem(20'h10000, 0, 0); mem(20'h30000, 0, 0); bad <= 0;
    io(16'h006b, 0, 0); chk_reg("planar", 16'h0000, r);
    io(16'h006b, 16'h0003, 1);
    mem(20'h00000, 0, 0); chk_mem("rows", 16'hbfff, m);
    mem(20'h80000, 0, 0); chk_mem("rows", 16'hffff, m);
    mem(20'h40000, 0, 0); chk_mem("rows", 16'hffff, m);
    io(16'h006b, 16'h0000, 1);
    io(16'h0011, 16'h0000, 1); io(16'h0012, 16'h0085, 1);
    mem(20'h40000, 0, 0); chk_mem("rows", 16'hffff, m);
    chk_mem("page", 16'h0005, {7'h00, pg});
    chk_mem("bank rows", 16'h000e, {12'h000, er});
    io(16'h0012, 16'h0005, 1);
    mem(20'h40000, 0, 0); chk_mem("rows", 16'hbfff, m);
    @(posedge clock) strap <= 0;
    mem(20'h30000, 1, 0); chk_mem("selects", 16'hff7f, m);
    mem(20'h20000, 0, 0); chk_mem("selects", 16'hffbf, m);
    io(16'h0012, 16'h008c, 1);
    mem(20'h40000, 0, 0); chk_mem("selects", 16'hfff3, m);
    conclude();
  end
endmodule : system_and_expanded_memory_map_test
